/* core/acq_fifo_status_user_io.sv */
/*
 * sample fifo with ready/overflow status, user digital i/o, indicator
 * lamp, gated host interrupt, supply status and common converter word.
 * assumes a single 100 mhz clock, a plain register port and external
 * converters that push one sample word per valid pulse on this clock.
 */
`timescale 1ns/1ns
module acq_fifo_status_user_io
	import acq_pkg::*;
#(
	parameter bit LARGE_FIFO = 1'b0, // eight-channel build
	parameter int DEPTH = LARGE_FIFO ? FIFO_DEPTH_LARGE : FIFO_DEPTH_SMALL
) (
	input wire logic clk_in, // system clock
	input wire logic rst_b_in, // async reset, active low
	input wire logic [REG_AW-1:0] reg_addr_in, // register byte address
	input wire logic [REG_DW-1:0] reg_wdata_in, // register write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	output logic [REG_DW-1:0] reg_rdata_out, // read data, next cycle
	input wire logic sample_valid_in, // converter word ready
	input wire logic [DATA_W-1:0] sample_data_in, // converter word
	input wire logic fifo_drain_request_in, // pop one word
	output logic [DATA_W-1:0] fifo_data_out, // popped word
	output logic fifo_data_valid_out, // popped word valid
	input wire logic [GP_N-1:0] gp_input_pins_in, // user input pins
	output logic [GP_N-1:0] gp_output_pins_out, // user output pins
	output logic indicator_lamp_out, // lamp drive, high is on
	input wire logic supply_in_range_in, // supply monitor pin
	output logic supply_ok_n_out, // error status line, low is good
	output logic host_irq_out, // port interrupt line
	output logic converters_run_out, // high lets converters sample
	output logic [CV_W-1:0] converter_ctrl_out // common settings
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [GP_N-1:0] gp_s1_q, gp_s2_q, gp_s3_q, gp_in_q;
	logic sup_s1_q, sup_s2_q, sup_s3_q, sup_q;

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			gp_s1_q <= '0;
			gp_s2_q <= '0;
			gp_s3_q <= '0;
			gp_in_q <= '0;
		end
		else
		begin
			gp_s1_q <= gp_input_pins_in;
			gp_s2_q <= gp_s1_q;
			gp_s3_q <= gp_s2_q;
			// a bit changes only once the second and third stage agree,
			// so a runt glitch on a pin never reaches the interrupt line
			for (int i = 0; i < GP_N; i++)
				if (gp_s2_q[i] == gp_s3_q[i])
					gp_in_q[i] <= gp_s3_q[i];
		end
	end

	// supply monitor pin, same filter as the user inputs
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
			sup_s3_q <= 1'b0;
			sup_q <= 1'b0;
		end
		else
		begin
			sup_s1_q <= supply_in_range_in;
			sup_s2_q <= sup_s1_q;
			sup_s3_q <= sup_s2_q;
			if (sup_s2_q == sup_s3_q)
				sup_q <= sup_s3_q;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	typedef enum logic {
		RUN_IDLE = 1'b0,
		RUN_ACTIVE = 1'b1
	} run_state_t;

	logic wr_ctl, wr_gp, wr_cv;
	logic gate_q, fifo_rst;
	logic start_req, stop_req;
	run_state_t run_q, run_d;
	logic [GP_N-1:0] gp_out_q;
	logic lamp_q;
	logic [CV_W-1:0] conv_q;

	assign wr_ctl = reg_wr_in && reg_addr_in == OFF_CONTROL;
	assign wr_gp = reg_wr_in && reg_addr_in == OFF_GP_IO;
	assign wr_cv = reg_wr_in && reg_addr_in == OFF_CONV;
	assign fifo_rst = wr_ctl && reg_wdata_in[CT_FIFO_RST];
	assign start_req = wr_ctl && reg_wdata_in[CT_START];
	assign stop_req = wr_ctl && reg_wdata_in[CT_STOP];

	// stop wins over a start in the same write, so a confused host
	// always leaves the converters idle
	always_comb
	begin
		run_d = run_q;
		case (run_q)
			RUN_IDLE:
				if (start_req && !stop_req)
					run_d = RUN_ACTIVE;
			RUN_ACTIVE:
				if (stop_req)
					run_d = RUN_IDLE;
			default:
				run_d = RUN_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			run_q <= RUN_IDLE;
		else
			run_q <= run_d;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			gate_q <= 1'b0;
		else if (wr_ctl && reg_wdata_in[CT_GATE_OFF])
			gate_q <= 1'b0;
		else if (wr_ctl && reg_wdata_in[CT_GATE_ON])
			gate_q <= 1'b1;
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			gp_out_q <= GP_OUT_RESET;
			lamp_q <= 1'b0;
		end
		else if (wr_gp)
		begin
			gp_out_q <= reg_wdata_in[GP_OUT_LSB +: GP_N];
			lamp_q <= reg_wdata_in[GP_LAMP];
		end
	end

	// settings only change while idle so no converter sees a half update
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			conv_q <= CONV_RESET;
		else if (wr_cv && !run_q)
			conv_q <= reg_wdata_in[CV_W-1:0];
	end

	// ----------------------------------------------------------------
	// sample fifo
	// ----------------------------------------------------------------
	logic [AW-1:0] wr_ptr_q, rd_ptr_q;
	logic [AW:0] count_q;
	logic ovf_q, push, pop, full, empty, pop_q;
	logic [DATA_W-1:0] mem_rd;

	assign full = count_q == DEPTH_C;
	assign empty = count_q == '0;
	// once overflowed, later samples are corrupt and dropped
	assign push = sample_valid_in && run_q && !full && !ovf_q;
	assign pop = fifo_drain_request_in && !empty;

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else if (fifo_rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q == AW'(DEPTH - 1) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q == AW'(DEPTH - 1) ? '0 : rd_ptr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end

	// full sets the latch; a fifo reset clears it unless full or a sample arrives while running
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			ovf_q <= 1'b0;
		else if (full || (sample_valid_in && run_q && ovf_q))
			ovf_q <= 1'b1;
		else if (fifo_rst)
			ovf_q <= 1'b0;
	end

	sample_mem #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk_in(clk_in),
		.wr_en_in(push),
		.wr_addr_in(wr_ptr_q),
		.wr_data_in(sample_data_in),
		.rd_addr_in(rd_ptr_q),
		.rd_data_out(mem_rd)
	);

	// a pop that meets a fifo reset must not present a stale word
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			pop_q <= 1'b0;
		else
			pop_q <= pop && !fifo_rst;
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			fifo_data_out <= '0;
			fifo_data_valid_out <= 1'b0;
		end
		else
		begin
			fifo_data_valid_out <= pop_q;
			if (pop_q)
				fifo_data_out <= mem_rd;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			gp_output_pins_out <= GP_OUT_RESET;
			indicator_lamp_out <= 1'b0;
			supply_ok_n_out <= 1'b1;
			host_irq_out <= 1'b0;
			converters_run_out <= 1'b0;
			converter_ctrl_out <= CONV_RESET;
		end
		else
		begin
			gp_output_pins_out <= gp_out_q;
			indicator_lamp_out <= lamp_q;
			supply_ok_n_out <= !sup_q;
			host_irq_out <= gate_q && !gp_in_q[GP_PPS_BIT];
			converters_run_out <= run_q;
			converter_ctrl_out <= conv_q;
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	logic [REG_DW-1:0] rd_d;

	always_comb
	begin
		rd_d = '0;
		case (reg_addr_in)
			OFF_STATUS:
			begin
				rd_d[ST_READY] = !empty;
				rd_d[ST_OVF] = ovf_q;
				rd_d[ST_SUPPLY] = !sup_q;
				rd_d[ST_IRQ] = gate_q;
				rd_d[ST_RUN] = run_q;
			end
			OFF_GP_IO:
			begin
				rd_d[GP_OUT_LSB +: GP_N] = gp_out_q;
				rd_d[GP_LAMP] = lamp_q;
				rd_d[GP_IN_LSB +: GP_N] = gp_in_q;
			end
			OFF_CONV:
				rd_d[CV_W-1:0] = conv_q;
			default:
				rd_d = '0;
		endcase
	end

	// data fall back to zero outside the answer cycle, so a late
	// sampler on the host never mistakes an old word for a new one

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			reg_rdata_out <= '0;
		else if (reg_rd_in)
			reg_rdata_out <= rd_d;
		else
			reg_rdata_out <= '0;
	end
endmodule

/* core/acq_pkg.sv */
/*
 * constants shared by the acquisition status and user i/o block:
 * register offsets, field positions, reset values and fifo sizes.
 * assumes a plain register port with word-wide data.
 */
package acq_pkg;
	localparam int DATA_W = 24;
	localparam int REG_AW = 4;
	localparam int REG_DW = 32;

	// ----------------------------------------------------------------
	// register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [REG_AW-1:0] OFF_STATUS = 4'h0;
	localparam logic [REG_AW-1:0] OFF_CONTROL = 4'h4;
	localparam logic [REG_AW-1:0] OFF_GP_IO = 4'h8;
	localparam logic [REG_AW-1:0] OFF_CONV = 4'hc;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	// status: ready, overflow, supply error, irq gate, running
	localparam int ST_READY = 0;
	localparam int ST_OVF = 1;
	localparam int ST_SUPPLY = 2;
	localparam int ST_IRQ = 3;
	localparam int ST_RUN = 4;
	// control (write 1 actions): start, stop, gate on, gate off, fifo reset
	localparam int CT_START = 0;
	localparam int CT_STOP = 1;
	localparam int CT_GATE_ON = 2;
	localparam int CT_GATE_OFF = 3;
	localparam int CT_FIFO_RST = 4;
	// gp io: outputs [3:0], lamp bit 4, inputs read at [11:8]
	localparam int GP_OUT_LSB = 0;
	localparam int GP_LAMP = 4;
	localparam int GP_IN_LSB = 8;
	localparam int GP_N = 4;
	localparam int GP_PPS_BIT = 3;
	// converter word: format bit 0, gain [3:1], turbo [6:4], dec [17:7]
	localparam int CV_DF = 0;
	localparam int CV_GAIN_LSB = 1;
	localparam int CV_TURBO_LSB = 4;
	localparam int CV_DEC_LSB = 7;
	localparam int CV_W = 18;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CV_W-1:0] CONV_RESET = 18'h00040;
	localparam logic [GP_N-1:0] GP_OUT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// fifo depth in words: 2 mbit and 4 mbit of 24-bit samples
	// ----------------------------------------------------------------
	localparam int FIFO_BITS_SMALL = 2097152;
	localparam int FIFO_BITS_LARGE = 4194304;
	localparam int FIFO_DEPTH_SMALL = FIFO_BITS_SMALL / DATA_W;
	localparam int FIFO_DEPTH_LARGE = FIFO_BITS_LARGE / DATA_W;
endpackage

/* core/sample_mem.sv */
/*
 * simple dual-port sample store with registered read data.
 * assumes one clock; caller guarantees addresses are in range.
 */
`timescale 1ns/1ns
module sample_mem #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_in, // system clock
	input wire logic wr_en_in, // write strobe
	input wire logic [AW-1:0] wr_addr_in, // write address
	input wire logic [WIDTH-1:0] wr_data_in, // write data
	input wire logic [AW-1:0] rd_addr_in, // read address
	output logic [WIDTH-1:0] rd_data_out // read data, one cycle later
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk_in)
	begin
		if (wr_en_in)
			mem_q[wr_addr_in] <= wr_data_in;
	end

	always_ff @(posedge clk_in)
	begin
		rd_data_out <= mem_q[rd_addr_in];
	end
endmodule

/* verif/acq_io_monitor.sv */
/* port checker for the acquisition status and user i/o block.
   assumes one clock and the register map of acq_pkg. */
`timescale 1ns/1ns
module acq_io_monitor
	import acq_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // reset, low
	input wire logic [REG_AW-1:0] reg_addr_in, // address
	input wire logic [REG_DW-1:0] reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic fifo_drain_request_in, // pop
	input wire logic fifo_data_valid_out, // popped valid
	input wire logic [GP_N-1:0] gp_input_pins_in, // input pins
	input wire logic [GP_N-1:0] gp_output_pins_out, // output pins
	input wire logic indicator_lamp_out, // lamp
	input wire logic supply_in_range_in, // supply monitor
	input wire logic supply_ok_n_out, // supply status
	input wire logic host_irq_out, // interrupt
	input wire logic converters_run_out, // run
	input wire logic [CV_W-1:0] converter_ctrl_out // settings
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// ----------------------------------------------------------------
	// steps
	// ----------------------------------------------------------------
	sequence s_gp_wr;
		reg_wr_in && reg_addr_in == OFF_GP_IO;
	endsequence
	sequence s_ctl_wr;
		reg_wr_in && reg_addr_in == OFF_CONTROL;
	endsequence
	sequence s_pin3_hi;
		gp_input_pins_in[GP_PPS_BIT] [*6];
	endsequence
	AST_GP_OUT: assert property (
		s_gp_wr |-> ##2
		gp_output_pins_out == $past(reg_wdata_in[GP_OUT_LSB +: GP_N], 2))
		else $error("gp outputs miss write");
	AST_LAMP: assert property (
		s_gp_wr |-> ##2
		indicator_lamp_out == $past(reg_wdata_in[GP_LAMP], 2))
		else $error("lamp misses write");
	AST_IRQ: assert property (s_pin3_hi |-> !host_irq_out)
		else $error("irq high with pin high");
	AST_GATE: assert property (
		s_ctl_wr ##0 reg_wdata_in[CT_GATE_OFF] |-> ##2 !host_irq_out)
		else $error("irq while gated off");
	AST_SUPPLY: assert property (
		supply_in_range_in [*6] |-> !supply_ok_n_out)
		else $error("supply status wrong");
	AST_RUN: assert property ($rose(converters_run_out) |->
		$past(reg_wr_in && reg_addr_in == OFF_CONTROL &&
		reg_wdata_in[CT_START] && !reg_wdata_in[CT_STOP], 2))
		else $error("run without start");
	AST_STOP: assert property (
		s_ctl_wr ##0 reg_wdata_in[CT_STOP] |-> ##2 !converters_run_out)
		else $error("run after stop");
	AST_CONV: assert property ($changed(converter_ctrl_out) |->
		$past(reg_wr_in && reg_addr_in == OFF_CONV, 2) &&
		!$past(converters_run_out))
		else $error("settings changed unasked");
	AST_POP: assert property (
		fifo_data_valid_out |-> $past(fifo_drain_request_in, 2))
		else $error("pop valid without request");
endmodule
bind acq_fifo_status_user_io acq_io_monitor mon_inst (.*);

/* verif/host_port_model.sv */
/* host side of the register port: writes, reads and fifo pops.
   assumes requests are sampled on the rising clk_in edge. */
`timescale 1ns/1ns
module host_port_model
	import acq_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic [REG_DW-1:0] reg_rdata_in, // read data
	output logic [REG_AW-1:0] reg_addr_out, // address
	output logic [REG_DW-1:0] reg_wdata_out, // write data
	output logic reg_wr_out, // write strobe
	output logic reg_rd_out, // read strobe
	output logic drain_out // pop one word
);
	initial
	begin
		reg_addr_out = 4'h0;
		reg_wdata_out = 32'h0;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		drain_out = 1'b0;
	end
	// settings reset to gain code 0 and turbo code 4
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	// polling both before and after start; fifo reset stands for reopen
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		#1 d = reg_rdata_in;
	endtask
	task automatic drain();
		@(posedge clk_in);
		drain_out <= 1'b1;
		@(posedge clk_in);
		drain_out <= 1'b0;
	endtask
endmodule

/* verif/acq_fifo_status_user_io_tb.sv */
/* self-checking bench for the acquisition status and user i/o block.
   assumes a fifo depth of 8 to keep the overflow run short. */
`timescale 1ns/1ns
module acq_fifo_status_user_io_tb;
	import acq_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, d;
	logic wr_s, rd_s, pop, sv = 1'b0, fv, lamp, sup = 1'b0, sup_n, irq, run;
	logic [23:0] sd = 24'h0, fd;
	logic [3:0] gp_in = 4'h0, gp_out;
	logic [17:0] conv;
	int err_total = 0;
	int n_compared = 0;
	always #5 clk_in = ~clk_in;
	host_port_model host_port_model_inst (.clk_in(clk_in),
		.reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr_s), .reg_rd_out(rd_s), .drain_out(pop));
	acq_fifo_status_user_io #(.DEPTH(8)) acq_fifo_status_user_io_inst (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .sample_valid_in(sv), .sample_data_in(sd),
		.fifo_drain_request_in(pop), .fifo_data_out(fd),
		.fifo_data_valid_out(fv), .gp_input_pins_in(gp_in),
		.gp_output_pins_out(gp_out), .indicator_lamp_out(lamp),
		.supply_in_range_in(sup), .supply_ok_n_out(sup_n),
		.host_irq_out(irq), .converters_run_out(run),
		.converter_ctrl_out(conv));
	task automatic chk(input string nm, input logic [63:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic w(input logic [3:0] a, input logic [31:0] v);
		host_port_model_inst.wr(a, v);
	endtask
	task automatic st(input logic [1:0] e); // ready and overflow bits
		host_port_model_inst.rd(OFF_STATUS, d);
		chk("status", d[1:0], e);
	endtask
	task automatic push(input logic [23:0] v);
		@(posedge clk_in);
		sv <= 1'b1;
		sd <= v;
		@(posedge clk_in);
		sv <= 1'b0;
		sd <= ~v;
	endtask
	task automatic pop_chk(input logic [23:0] e);
		host_port_model_inst.drain();
		@(posedge clk_in);
		#1;
		chk("pop", {fv, fd}, {1'b1, e});
	endtask
	task automatic t_gpio();
		w(OFF_GP_IO, 32'h1a);
		gp_in <= 4'h5;
		w(OFF_CONTROL, 32'h4);
		repeat (6) @(posedge clk_in);
		chk("pins", {lamp, gp_out, irq}, 6'h35);
		host_port_model_inst.rd(OFF_GP_IO, d);
		chk("gp read", d[11:0], 12'h51a);
		gp_in <= 4'h8;
		repeat (6) @(posedge clk_in);
		chk("irq", irq, 1'b0);
		gp_in <= 4'h0;
		w(OFF_CONTROL, 32'h8);
		w(OFF_GP_IO, 32'h0);
		repeat (6) @(posedge clk_in);
		chk("gated", {lamp, irq}, 2'b00);
	endtask
	task automatic t_conv();
		for (int i = 0; i < 2; i++)
		begin
			sup <= ~sup;
			repeat (6) @(posedge clk_in);
			chk("supply", sup_n, !sup);
		end
		w(OFF_CONV, 32'h1);
		host_port_model_inst.rd(OFF_CONV, d);
		chk("conv", {d, conv}, {32'h1, 18'h1});
		w(OFF_CONTROL, 32'h1);
		w(OFF_CONV, 32'h3ffff);
		host_port_model_inst.rd(OFF_CONV, d);
		chk("conv run", {d, run}, {32'h1, 1'b1});
		w(OFF_CONTROL, 32'h2);
	endtask
	task automatic t_fifo();
		push(24'h111111);
		st(2'b00);
		w(OFF_CONTROL, 32'h1);
		push(24'habcdef);
		st(2'b01);
		pop_chk(24'habcdef);
		st(2'b00);
		for (int i = 0; i < 7; i++)
			push(24'h100 + 24'(i));
		st(2'b01);
		push(24'h107);
		push(24'hdeadbe);
		st(2'b11);
		for (int i = 0; i < 8; i++)
			pop_chk(24'h100 + 24'(i));
		st(2'b10);
		w(OFF_CONTROL, 32'h12);
		st(2'b00);
		host_port_model_inst.rd(OFF_STATUS, d);
		chk("stopped", d[ST_RUN], 1'b0);
	endtask
	task automatic t_reset();
		w(OFF_GP_IO, 32'h1f);
		w(OFF_CONTROL, 32'h5);
		for (int i = 0; i < 9; i++)
			push(24'h200 + 24'(i));
		st(2'b11);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		st(2'b00);
		host_port_model_inst.rd(OFF_STATUS, d);
		chk("reset ctl", d[ST_RUN:ST_IRQ], 2'b00);
		chk("reset pins", {lamp, gp_out, irq, run}, 7'h00);
	endtask
	initial
	begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		st(2'b00);
		host_port_model_inst.rd(OFF_CONV, d);
		chk("conv reset", d, {14'h0, CONV_RESET});
		host_port_model_inst.rd(4'h2, d);
		chk("unmapped", d, 32'h0);
		chk("gp reset", {lamp, gp_out}, 5'h00);
		t_gpio();
		t_conv();
		t_fifo();
		t_reset();
		results();
	end
	// watchdog: a hang counts as a mismatch
	initial
	begin
		#200000;
		err_total++;
		results();
	end
endmodule
